/* File: mbw_pkg.sv */
// constants and types shared by the modbus slave with host timeout supervision
package mbw_pkg;

  // ==========================================================
  // function selectors and exception codes
  localparam logic [7:0] FS_RD_COILS = 8'h01;
  localparam logic [7:0] FS_RD_INPUTS = 8'h02;
  localparam logic [7:0] FS_RD_HOLD = 8'h03;
  localparam logic [7:0] FS_RD_INREG = 8'h04;
  localparam logic [7:0] FS_WR_COIL = 8'h05;
  localparam logic [7:0] FS_WR_REG = 8'h06;
  localparam logic [7:0] FS_WR_COILS = 8'h0F;
  localparam logic [7:0] FS_PROG_A = 8'h0D;
  localparam logic [7:0] FS_PROG_B = 8'h0E;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_VALUE = 8'h03;
  localparam logic [7:0] EX_FAIL = 8'h04;
  localparam logic [7:0] EX_ACK = 8'h05;
  localparam logic [7:0] EX_BUSY = 8'h06;
  localparam logic [7:0] EX_NAK = 8'h07;
  localparam logic [7:0] EX_PARITY = 8'h08;

  // ==========================================================
  // holding register map, zero based
  localparam logic [15:0] REG_HOST_TIMEOUT_ENABLE = 16'h0000;
  localparam logic [15:0] REG_HOST_TIMEOUT_PERIOD = 16'h0001;
  localparam logic [15:0] REG_HOST_TIMEOUT_STATUS = 16'h0002;
  localparam int unsigned PLC_HOLD_BASE = 40001;
  localparam logic [15:0] NUM_HOLD = 16'h0003;
  localparam logic [15:0] NUM_COILS = 16'h0008;
  localparam logic [15:0] NUM_INPUTS = 16'h0008;
  localparam logic [15:0] NUM_INREG = 16'h0001;
  localparam logic [15:0] WORD_OFF = 16'h0000;
  localparam logic [15:0] WORD_ON = 16'hFF00;
  localparam logic [15:0] PERIOD_MIN = 16'h0001;
  localparam logic [15:0] PERIOD_MAX = 16'h00FF;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h000A;
  localparam logic [7:0] COILS_RST = 8'h00;

  // ==========================================================
  // framing and check field
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int BUF_DEPTH = 16;
  localparam logic [4:0] LEN_MIN = 5'h04;
  localparam logic [4:0] LEN_FIXED = 5'h08;
  localparam logic [4:0] LEN_MULTI = 5'h0A;

  // ==========================================================
  // timing: timeout unit of 0.1 s on a 100 ns clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WD_UNIT_NS = 100000000;
  localparam int unsigned WD_UNIT_CYCLES = WD_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_SEND = 3'b011,
    ST_CRCL = 3'b010,
    ST_CRCH = 3'b110
  } mbw_state_e;

endpackage

/* File: mbw_slave.sv */
// modbus slave command handler with host timeout supervision
// Function
// - read coils 01, read inputs 02
// - read holding 03, input registers 04
// - 05 forces one coil on or off
// - 06 writes one 16-bit register
// - 15 forces run of consecutive coils
// - answer only queries, never unsolicited
// - check received crc, append sent crc
// - exception frame: address, function, code, crc
// - exception sets function msb
// - code 01 for unsupported function
// - code 02 for bad address
// - code 03 for bad value
// - code 04 on device failure
// - code 05 for accepted long request
// - code 06 while busy
// - code 07 for program functions
// - code 08 on memory parity error in a 03 or 04 read
// - zero-based addresses, plc number plus 40001
// - configuration registers are holding registers
// - enable register 0000H off, FF00H on
// - period 0001H-00FFH, units of 0.1 s
// - address 0002 reads timeout status
// - status 0000H healthy, FF00H failed
// - writing FF00H to status clears failure
`timescale 1ns/10ps
module mbw_slave
  import mbw_pkg::*;
#(
  parameter int unsigned WD_TICK_CYCLES = WD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // request byte stream
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_last,
  input wire logic [7:0] i_slave_addr,
  // response byte stream
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  // field i/o
  input wire logic [7:0] i_din,
  output logic [7:0] o_dout,
  // device condition
  input wire logic i_dev_fault,
  input wire logic i_dev_busy,
  input wire logic i_defer_ack,
  input wire logic i_mem_parity_err,
  // supervision
  output logic o_wd_fail
);

  localparam int TW = $clog2(WD_TICK_CYCLES + 1);

  // ==========================================================
  // helpers
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic fits(input logic [15:0] a, input logic [15:0] q,
                                input logic [15:0] lim);
    return ({1'b0, a} + {1'b0, q}) <= {1'b0, lim};
  endfunction

  mbw_state_e state_q;
  logic [7:0] rx_buf [BUF_DEPTH];
  logic [7:0] tx_buf [BUF_DEPTH];
  logic [4:0] rx_cnt_q, rx_len_q, tx_len_q, tx_idx_q;
  logic rx_ovf_q, rx_done_q, rx_ok_q;
  logic [15:0] rx_crc_q, tx_crc_q, rx_crc_d;
  logic [7:0] din_s1_q, din_s2_q, dout_q;
  logic [15:0] enable_q, period_q;
  logic wd_fail_q, wd_expire;
  logic [TW-1:0] tick_q;
  logic [7:0] units_q;
  logic [7:0] tx_byte_q;
  logic tx_valid_q, tx_last_q;

  // ==========================================================
  // input synchroniser for field inputs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= i_din;
      din_s2_q <= din_s1_q;
    end
  end

  // ==========================================================
  // frame reception, bytes ignored while a frame is being served
  logic rx_take;
  assign rx_take = i_rx_valid && (state_q == ST_IDLE) && !rx_done_q;
  assign rx_crc_d = crc_byte(rx_crc_q, i_rx_byte);

  always_ff @(posedge i_core_clk) begin
    if (rx_take && (rx_cnt_q < 5'(BUF_DEPTH))) begin
      rx_buf[rx_cnt_q[3:0]] <= i_rx_byte;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_cnt_q <= 5'h00;
      rx_len_q <= 5'h00;
      rx_ovf_q <= 1'b0;
      rx_crc_q <= CRC_INIT;
      rx_done_q <= 1'b0;
      rx_ok_q <= 1'b0;
    end else begin
      rx_done_q <= rx_take && i_rx_last;
      if (rx_take) begin
        if (i_rx_last) begin
          rx_cnt_q <= 5'h00;
          rx_ovf_q <= 1'b0;
          rx_crc_q <= CRC_INIT;
          rx_len_q <= rx_cnt_q + 5'h01;
          // crc over frame plus its check field leaves zero
          rx_ok_q <= (rx_crc_d == 16'h0000) && !rx_ovf_q && (rx_cnt_q < 5'(BUF_DEPTH)) &&
                     (rx_cnt_q + 5'h01 >= LEN_MIN) && (rx_buf[0] == i_slave_addr);
        end else begin
          rx_crc_q <= rx_crc_d;
          if (rx_cnt_q == 5'(BUF_DEPTH)) begin
            rx_ovf_q <= 1'b1;
          end else begin
            rx_cnt_q <= rx_cnt_q + 5'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // request decode
  logic [7:0] fsel, exc;
  logic [15:0] addr, val;
  logic is_write, do_write;
  assign fsel = rx_buf[1];
  assign addr = {rx_buf[2], rx_buf[3]};
  assign val = {rx_buf[4], rx_buf[5]};
  assign is_write = (fsel == FS_WR_COIL) || (fsel == FS_WR_REG) || (fsel == FS_WR_COILS);

  always_comb begin
    exc = EX_NONE;
    if ((fsel == FS_PROG_A) || (fsel == FS_PROG_B)) begin
      exc = EX_NAK;
    end else if (!(fsel inside {FS_RD_COILS, FS_RD_INPUTS, FS_RD_HOLD, FS_RD_INREG,
                                FS_WR_COIL, FS_WR_REG, FS_WR_COILS})) begin
      exc = EX_FUNC;
    end else if (i_dev_busy) begin
      exc = EX_BUSY;
    end else if (rx_len_q != ((fsel == FS_WR_COILS) ? LEN_MULTI : LEN_FIXED)) begin
      exc = EX_VALUE;
    end else begin
      case (fsel)
        FS_RD_COILS, FS_RD_INPUTS: begin
          if ((val == 16'h0000) || (val > NUM_COILS)) exc = EX_VALUE;
          else if (!fits(addr, val, NUM_INPUTS)) exc = EX_ADDR;
        end
        FS_RD_HOLD: begin
          if ((val == 16'h0000) || (val > NUM_HOLD)) exc = EX_VALUE;
          else if (!fits(addr, val, NUM_HOLD)) exc = EX_ADDR;
        end
        FS_RD_INREG: begin
          if ((val == 16'h0000) || (val > NUM_INREG)) exc = EX_VALUE;
          else if (!fits(addr, val, NUM_INREG)) exc = EX_ADDR;
        end
        FS_WR_COIL: begin
          if (addr >= NUM_COILS) exc = EX_ADDR;
          else if ((val != WORD_OFF) && (val != WORD_ON)) exc = EX_VALUE;
        end
        FS_WR_REG: begin
          if (addr >= NUM_HOLD) exc = EX_ADDR;
          else if (addr == REG_HOST_TIMEOUT_ENABLE) begin
            if ((val != WORD_OFF) && (val != WORD_ON)) exc = EX_VALUE;
          end else if (addr == REG_HOST_TIMEOUT_PERIOD) begin
            if ((val < PERIOD_MIN) || (val > PERIOD_MAX)) exc = EX_VALUE;
          end else if (val != WORD_ON) exc = EX_VALUE;
        end
        default: begin
          if ((val == 16'h0000) || (val > NUM_COILS) || (rx_buf[6] != 8'h01)) exc = EX_VALUE;
          else if (!fits(addr, val, NUM_COILS)) exc = EX_ADDR;
        end
      endcase
      if (exc == EX_NONE) begin
        if (i_dev_fault) exc = EX_FAIL;
        else if (i_mem_parity_err && (fsel == FS_RD_HOLD || fsel == FS_RD_INREG)) begin
          exc = EX_PARITY;
        end else if (i_defer_ack && is_write) exc = EX_ACK;
      end
    end
  end

  // a deferred write is still carried out, only the answer differs
  assign do_write = (state_q == ST_EXEC) && rx_ok_q && is_write &&
                    ((exc == EX_NONE) || (exc == EX_ACK));

  // ==========================================================
  // coils
  logic [7:0] run_mask;
  assign run_mask = ~(8'hFF << val[3:0]);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      dout_q <= COILS_RST;
    end else if (do_write && (fsel == FS_WR_COIL)) begin
      dout_q[addr[2:0]] <= (val == WORD_ON);
    end else if (do_write && (fsel == FS_WR_COILS)) begin
      dout_q <= (dout_q & ~(run_mask << addr[2:0])) |
                ((rx_buf[7] & run_mask) << addr[2:0]);
    end
  end

  // ==========================================================
  // host timeout registers and timer
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_q <= ENABLE_RST;
      period_q <= PERIOD_RST;
    end else if (do_write && (fsel == FS_WR_REG)) begin
      if (addr == REG_HOST_TIMEOUT_ENABLE) enable_q <= val;
      if (addr == REG_HOST_TIMEOUT_PERIOD) period_q <= val;
    end
  end

  // any accepted frame for this slave counts as host activity
  logic wd_kick;
  assign wd_kick = (enable_q != WORD_ON) || (state_q == ST_EXEC && rx_ok_q);
  assign wd_expire = !wd_kick && (tick_q == TW'(WD_TICK_CYCLES - 1)) &&
                     (units_q + 8'h01 >= period_q[7:0]);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_q <= '0;
      units_q <= 8'h00;
    end else if (wd_kick || wd_expire) begin
      tick_q <= '0;
      units_q <= 8'h00;
    end else if (tick_q == TW'(WD_TICK_CYCLES - 1)) begin
      tick_q <= '0;
      units_q <= units_q + 8'h01;
    end else begin
      tick_q <= tick_q + TW'(1);
    end
  end

  // expiry wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wd_fail_q <= 1'b0;
    end else if (wd_expire) begin
      wd_fail_q <= 1'b1;
    end else if (do_write && (fsel == FS_WR_REG) && (addr == REG_HOST_TIMEOUT_STATUS)) begin
      wd_fail_q <= 1'b0;
    end
  end

  function automatic logic [15:0] hold_word(input logic [15:0] idx);
    case (idx)
      REG_HOST_TIMEOUT_ENABLE: return enable_q;
      REG_HOST_TIMEOUT_PERIOD: return period_q;
      REG_HOST_TIMEOUT_STATUS: return wd_fail_q ? WORD_ON : WORD_OFF;
      default: return 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // response assembly
  logic [7:0] bit_src;
  logic [15:0] rd_word [3];
  assign bit_src = (fsel == FS_RD_COILS) ? dout_q : din_s2_q;

  // read words formed outside the clocked process, which then only latches them
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rd_word[i] = (fsel == FS_RD_HOLD) ? hold_word(addr + 16'(i)) : {8'h00, din_s2_q};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (state_q == ST_EXEC) begin
      tx_buf[0] <= rx_buf[0];
      if (exc != EX_NONE) begin
        tx_buf[1] <= fsel | EXC_FLAG;
        tx_buf[2] <= exc;
      end else begin
        tx_buf[1] <= fsel;
        case (fsel)
          FS_RD_COILS, FS_RD_INPUTS: begin
            tx_buf[2] <= 8'h01;
            tx_buf[3] <= (bit_src >> addr[2:0]) & run_mask;
          end
          FS_RD_HOLD, FS_RD_INREG: begin
            tx_buf[2] <= {val[6:0], 1'b0};
            for (int i = 0; i < 3; i++) begin
              tx_buf[3 + 2 * i] <= rd_word[i][15:8];
              tx_buf[4 + 2 * i] <= rd_word[i][7:0];
            end
          end
          default: begin
            for (int i = 2; i < 6; i++) tx_buf[i] <= rx_buf[i];
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_len_q <= 5'h00;
    end else if (state_q == ST_EXEC) begin
      if (exc != EX_NONE) tx_len_q <= 5'h03;
      else if (fsel == FS_RD_COILS || fsel == FS_RD_INPUTS) tx_len_q <= 5'h04;
      else if (fsel == FS_RD_HOLD || fsel == FS_RD_INREG) tx_len_q <= 5'h03 + {val[3:0], 1'b0};
      else tx_len_q <= 5'h06;
    end
  end

  // ==========================================================
  // sequencer and transmit stream
  logic [15:0] tx_crc_d;
  assign tx_crc_d = crc_byte(tx_crc_q, tx_byte_q);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_idx_q <= 5'h00;
      tx_crc_q <= CRC_INIT;
    end else begin
      case (state_q)
        ST_IDLE: if (rx_done_q) state_q <= ST_EXEC;
        ST_EXEC: begin
          // a frame with a bad check or foreign address gets no answer
          state_q <= rx_ok_q ? ST_SEND : ST_IDLE;
          tx_idx_q <= 5'h00;
          tx_crc_q <= CRC_INIT;
        end
        ST_SEND: begin
          if (!tx_valid_q) begin
            tx_valid_q <= 1'b1;
            tx_byte_q <= tx_buf[tx_idx_q[3:0]];
          end else if (i_tx_ready) begin
            tx_crc_q <= tx_crc_d;
            tx_idx_q <= tx_idx_q + 5'h01;
            if (tx_idx_q + 5'h01 == tx_len_q) begin
              tx_byte_q <= tx_crc_d[7:0];
              state_q <= ST_CRCL;
            end else begin
              tx_byte_q <= tx_buf[4'(tx_idx_q + 5'h01)];
            end
          end
        end
        ST_CRCL: if (i_tx_ready) begin
          tx_byte_q <= tx_crc_q[15:8];
          tx_last_q <= 1'b1;
          state_q <= ST_CRCH;
        end
        ST_CRCH: if (i_tx_ready) begin
          tx_valid_q <= 1'b0;
          tx_last_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign o_tx_valid = tx_valid_q;
  assign o_tx_byte = tx_byte_q;
  assign o_tx_last = tx_last_q;
  assign o_dout = dout_q;
  assign o_wd_fail = wd_fail_q;

endmodule

/* File: mbw_checker.sv */
// concurrent checks on the modbus slave ports
`timescale 1ns/10ps
module mbw_checker
  import mbw_pkg::*;
#(
  parameter int unsigned WD_TICK_CYCLES = WD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // request stream
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_last,
  input wire logic [7:0] i_slave_addr,
  // response stream
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic o_tx_last,
  input wire logic i_tx_ready,
  // field and condition
  input wire logic [7:0] i_din,
  input wire logic [7:0] o_dout,
  input wire logic i_dev_fault,
  input wire logic i_dev_busy,
  input wire logic i_defer_ack,
  input wire logic i_mem_parity_err,
  input wire logic o_wd_fail
);
  // ======
  // frame tracking
  logic pend_q;
  logic exc_q;
  logic [3:0] rx_n_q;
  logic [3:0] tx_n_q;
  logic [7:0] fs_q;
  wire tx_hs = o_tx_valid && i_tx_ready;
  // a refused frame leaves pend_q set: weakens the unsolicited, failure-clear and coil-cause checks
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) pend_q <= 1'b0;
    else if (i_rx_valid && i_rx_last) pend_q <= 1'b1;
    else if (tx_hs && o_tx_last) pend_q <= 1'b0;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) rx_n_q <= 4'h0;
    else if (i_rx_valid) rx_n_q <= i_rx_last ? 4'h0 : rx_n_q + 4'h1;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) fs_q <= 8'h00;
    else if (i_rx_valid && rx_n_q == 4'h1) fs_q <= i_rx_byte;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) tx_n_q <= 4'h0;
    else if (tx_hs) tx_n_q <= o_tx_last ? 4'h0 : tx_n_q + 4'h1;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) exc_q <= 1'b0;
    else if (tx_hs && tx_n_q == 4'h1) exc_q <= o_tx_byte[7];
  end
  // ======
  // properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_no_unsolicited: assert property ($rose(o_tx_valid) |-> pend_q)
    else $error("reply without query");
  chk_tx_stands: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last)) else $error("reply byte moved");
  chk_last_release: assert property (tx_hs && o_tx_last |=> !o_tx_valid)
    else $error("valid after last");
  chk_addr_echo: assert property (tx_hs && tx_n_q == 4'h0 |-> o_tx_byte == i_slave_addr)
    else $error("address not echoed");
  chk_fs_echo: assert property (tx_hs && tx_n_q == 4'h1 |-> o_tx_byte[6:0] == fs_q[6:0])
    else $error("selector not echoed");
  chk_exc_code: assert property (tx_hs && tx_n_q == 4'h2 && exc_q |->
    o_tx_byte inside {[EX_FUNC:EX_PARITY]}) else $error("bad exception code");
  chk_exc_short: assert property (tx_hs && o_tx_last && exc_q |-> tx_n_q == 4'h4)
    else $error("exception length");
  chk_unsup_func: assert property (tx_hs && tx_n_q == 4'h1 && !(fs_q inside
    {[8'h01:8'h06], 8'h0D, 8'h0E, 8'h0F}) |-> o_tx_byte == (fs_q | EXC_FLAG))
    else $error("unsupported selector answered");
  chk_fail_clear: assert property ($fell(o_wd_fail) |-> $past(pend_q))
    else $error("failure cleared without request");
  chk_coil_cause: assert property ($changed(o_dout) |-> $past(pend_q))
    else $error("coils moved without request");
  cover property (tx_hs && tx_n_q == 4'h2 && exc_q);
  cover property ($rose(o_wd_fail));
  cover property ($fell(o_wd_fail));
endmodule

/* File: mbw_host.sv */
// host master model: crc framed queries, collects replies
`timescale 1ns/10ps
module mbw_host (
  // clock
  input wire logic i_core_clk,
  // reply from slave
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_last,
  // query to slave
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rx_last,
  output logic o_tx_ready
);
  bit stall = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_rx_last = 1'b0;
    o_tx_ready = 1'b0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // ======
  // one query; reply is returned without its crc
  task automatic query(input logic [7:0] q[$], input bit bad, output logic [7:0] r[$],
                       output bit to, output bit ok);
    logic [15:0] c;
    c = crc16(q) ^ (bad ? 16'h0101 : 16'h0000);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    r = {};
    to = 1'b1;
    foreach (q[i]) begin
      @(negedge i_core_clk);
      o_rx_valid = 1'b1;
      o_rx_byte = q[i];
      o_rx_last = (i == q.size() - 1);
    end
    @(negedge i_core_clk);
    o_rx_valid = 1'b0;
    o_rx_last = 1'b0;
    // released line must not keep showing the last byte
    o_rx_byte = ~o_rx_byte;
    for (int n = 0; n < 100 && to; n++) begin
      @(negedge i_core_clk);
      o_tx_ready = stall ? ~o_tx_ready : 1'b1;
      if (i_tx_valid && o_tx_ready) begin
        r.push_back(i_tx_byte);
        to = !i_tx_last;
      end
    end
    @(negedge i_core_clk);
    o_tx_ready = 1'b0;
    ok = (crc16(r) == 16'h0000);
    if (r.size() >= 2) r = r[0:$-2];
  endtask
endmodule

/* File: mbw_slave_test.sv */
// self-checking bench for the modbus slave with host timeout
`timescale 1ns/10ps
module mbw_slave_test;
  import mbw_pkg::*;
  typedef logic [7:0] mbw_bytes_t[$];
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, wd_fail;
  logic [7:0] rx_byte, tx_byte, dout;
  logic [7:0] din = 8'h5A;
  logic [3:0] cond = 4'h0;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] xf[11] = '{8'h07, FS_RD_HOLD, FS_WR_COIL, FS_RD_HOLD, FS_WR_REG, FS_RD_HOLD,
                         FS_PROG_A, FS_RD_INREG, FS_WR_REG, FS_RD_COILS, FS_PROG_B};
  logic [15:0] xa[11] = '{16'h0, 16'h3, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h6,
                          16'h0};
  logic [15:0] xv[11] = '{16'h1, 16'h1, 16'h1234, 16'h1, 16'h0, 16'h1, 16'h1, 16'h1, 16'h100,
                          16'h3, 16'h1};
  logic [3:0] xc[11] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h2, 4'h4, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};
  logic [7:0] xe[11] = '{EX_FUNC, EX_ADDR, EX_VALUE, EX_FAIL, EX_ACK, EX_BUSY, EX_NAK,
                         EX_PARITY, EX_VALUE, EX_ADDR, EX_NAK};
  always #50 i_core_clk = ~i_core_clk;
  mbw_slave #(.WD_TICK_CYCLES(10)) i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
    .i_rx_last(rx_last), .i_slave_addr(8'h01), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
    .o_tx_last(tx_last), .i_tx_ready(tx_ready), .i_din(din), .o_dout(dout),
    .i_dev_fault(cond[3]), .i_dev_busy(cond[2]), .i_defer_ack(cond[1]),
    .i_mem_parity_err(cond[0]), .o_wd_fail(wd_fail));
  mbw_host i_host (
    .i_core_clk(i_core_clk), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .i_tx_last(tx_last),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_last(rx_last), .o_tx_ready(tx_ready));
  // ======
  // tasks
  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  function automatic mbw_bytes_t req(input logic [7:0] fs, input logic [15:0] a, v);
    return '{8'h01, fs, a[15:8], a[7:0], v[15:8], v[7:0]};
  endfunction
  task automatic xact(input mbw_bytes_t q, input mbw_bytes_t e);
    mbw_bytes_t r;
    bit to;
    bit ok;
    i_host.query(q, 1'b0, r, to, ok);
    if (to) begin
      n_fail++;
      $display("MISMATCH reply exp frame got none");
      test_done();
    end
    cmp("reply crc", 16'h0001, {15'h0000, ok});
    cmp("reply length", 16'(e.size()), 16'(r.size()));
    foreach (e[i]) if (i < r.size()) cmp("reply byte", {8'h00, e[i]}, {8'h00, r[i]});
  endtask
  task automatic echo(input logic [7:0] fs, input logic [15:0] a, v);
    xact(req(fs, a, v), req(fs, a, v));
  endtask
  task automatic silent(input mbw_bytes_t q, input bit bad);
    mbw_bytes_t r;
    bit to;
    bit ok;
    i_host.query(q, bad, r, to, ok);
    cmp("silence", 16'h0001, {15'h0000, to});
  endtask
  task automatic flag(input logic exp);
    cmp("timeout flag", {15'h0000, exp}, {15'h0000, wd_fail});
  endtask
  // ======
  // main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    xact(req(FS_RD_HOLD, REG_HOST_TIMEOUT_ENABLE, 16'h0003), '{8'h01, FS_RD_HOLD, 8'h06,
         8'h00, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00});
    // slow sink keeps reply bytes standing
    i_host.stall = 1'b1;
    echo(FS_WR_COIL, 16'h0003, WORD_ON);
    cmp("coils", 16'h0008, {8'h00, dout});
    xact('{8'h01, FS_WR_COILS, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h0A},
         req(FS_WR_COILS, 16'h0004, 16'h0004));
    cmp("coils", 16'h00A8, {8'h00, dout});
    xact(req(FS_RD_COILS, 16'h0000, 16'h0008), '{8'h01, FS_RD_COILS, 8'h01, 8'hA8});
    xact(req(FS_RD_COILS, 16'h0006, 16'h0002), '{8'h01, FS_RD_COILS, 8'h01, 8'h02});
    xact(req(FS_RD_INPUTS, 16'h0000, 16'h0008), '{8'h01, FS_RD_INPUTS, 8'h01, 8'h5A});
    xact(req(FS_RD_INREG, 16'h0000, 16'h0001), '{8'h01, FS_RD_INREG, 8'h02, 8'h00, 8'h5A});
    i_host.stall = 1'b0;
    foreach (xf[i]) begin
      // one write of cond per falling edge: the query just ended there
      cond = xc[i];
      xact(req(xf[i], xa[i], xv[i]),
           '{8'h01, xf[i] | EXC_FLAG, xe[i]});
    end
    cond = 4'h0;
    // frame one byte too long for a fixed-size request
    xact('{8'h01, FS_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00},
         '{8'h01, FS_RD_HOLD | EXC_FLAG, EX_VALUE});
    echo(FS_WR_REG, REG_HOST_TIMEOUT_PERIOD, 16'h0003);
    echo(FS_WR_REG, REG_HOST_TIMEOUT_ENABLE, WORD_ON);
    repeat (10) @(negedge i_core_clk);
    flag(1'b0);
    repeat (25) @(negedge i_core_clk);
    flag(1'b1);
    xact(req(FS_RD_HOLD, REG_HOST_TIMEOUT_STATUS, 16'h0001),
         '{8'h01, FS_RD_HOLD, 8'h02, 8'hFF, 8'h00});
    echo(FS_WR_REG, REG_HOST_TIMEOUT_STATUS, WORD_ON);
    flag(1'b0);
    echo(FS_WR_REG, REG_HOST_TIMEOUT_ENABLE, WORD_OFF);
    repeat (60) @(negedge i_core_clk);
    flag(1'b0);
    silent(req(FS_RD_HOLD, 16'h0000, 16'h0001), 1'b1);
    silent('{8'h02, FS_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    xact(req(FS_RD_HOLD, REG_HOST_TIMEOUT_PERIOD, 16'h0001),
         '{8'h01, FS_RD_HOLD, 8'h02, 8'h00, 8'h03});
    test_done();
  end
endmodule
bind mbw_slave mbw_checker #(.WD_TICK_CYCLES(WD_TICK_CYCLES)) i_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte),
  .i_rx_last(i_rx_last), .i_slave_addr(i_slave_addr), .o_tx_valid(o_tx_valid),
  .o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready), .i_din(i_din),
  .o_dout(o_dout), .i_dev_fault(i_dev_fault), .i_dev_busy(i_dev_busy),
  .i_defer_ack(i_defer_ack), .i_mem_parity_err(i_mem_parity_err), .o_wd_fail(o_wd_fail));
